// [window_pkg.sv]
package window_pkg;

  // Host side geometry
  localparam int         HOST_ADDR_W    = 20;
  localparam int         WIN_OFS_W      = 14;
  localparam int         BASE_SEL_W     = 5;
  localparam logic       WIN_BASE_TOP   = 1'b1;
  localparam int         BANK_OFS_W     = 13;

  // Window offsets
  localparam logic [13:0] FIRST_BANK_END = 14'h1CFF;
  localparam logic [13:0] PAGE_OFS       = 14'h1D00;
  localparam logic [13:0] ACK_OFS        = 14'h1E00;
  localparam logic [13:0] REG_OFS        = 14'h1F00;
  localparam logic [13:0] SECOND_BANK    = 14'h2000;

  // Shared RAM and page register
  localparam int          RAM_ADDR_W     = 18;
  localparam int          PAGE_W         = 5;
  localparam logic [4:0]  PAGE_RESET     = 5'h00;
  localparam logic        DTR_RESET      = 1'b0;
  localparam logic [7:0]  IDLE_READ      = 8'hFF;

  // Serial controller straps and clock
  localparam logic [1:0]  SC_BUS_MODE    = 2'h0;
  localparam longint      MCLK_HZ        = 100000000;
  localparam longint      SC_CLK_HZ      = 9830400;
  localparam logic [31:0] SC_CLK_INC     = 32'((SC_CLK_HZ << 32) / MCLK_HZ);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAM  = 2'b01,
    ST_SC   = 2'b10,
    ST_DONE = 2'b11
  } access_state_t;

  typedef enum logic [2:0] {
    RG_BANK0 = 3'b000,
    RG_PAGE  = 3'b001,
    RG_ACK   = 3'b010,
    RG_REG   = 3'b011,
    RG_BANK1 = 3'b100
  } region_t;

  function automatic region_t decode_region(input logic [13:0] ofs);
    if (ofs >= SECOND_BANK) begin
      return RG_BANK1;
    end else if (ofs <= FIRST_BANK_END) begin
      return RG_BANK0;
    end else if (ofs[9:8] == PAGE_OFS[9:8]) begin
      return RG_PAGE;
    end else if (ofs[9:8] == ACK_OFS[9:8]) begin
      return RG_ACK;
    end
    return RG_REG;
  endfunction

endpackage

// [shared_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module shared_ram
  import window_pkg::*;
#(
  parameter int ADDR_W = RAM_ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              a_en,
  input  wire logic              a_we,
  input  wire logic [ADDR_W-1:0] a_addr,
  input  wire logic [7:0]        a_wdata,
  output logic      [7:0]        a_rdata,
  input  wire logic              b_en,
  input  wire logic              b_we,
  input  wire logic [ADDR_W-1:0] b_addr,
  input  wire logic [7:0]        b_wdata,
  output logic      [7:0]        b_rdata
);
  // Every page of the window must land inside the array
  if (ADDR_W < BANK_OFS_W + PAGE_W) begin : g_size_check
    $error("shared_ram too small for all pages");
  end

  logic [7:0] mem [2**ADDR_W];

  // Same-address writes in one cycle: host port lands last
  always_ff @(posedge mclk) begin
    if (b_en && b_we) mem[b_addr] <= b_wdata;
    if (b_en) b_rdata <= mem[b_addr];
    if (a_en && a_we) mem[a_addr] <= a_wdata;
    if (a_en) a_rdata <= mem[a_addr];
  end
endmodule
`default_nettype wire

// [sc_clock_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module sc_clock_gen
  import window_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  output logic      sc_clk
);
  // 9.8304 MHz is no divisor of mclk; edges jitter by one mclk period
  logic [31:0] phase;
  logic [31:0] next_phase;

  always_comb begin
    next_phase = phase + SC_CLK_INC;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase  <= 32'h0000_0000;
      sc_clk <= 1'b0;
    end else begin
      phase  <= next_phase;
      sc_clk <= next_phase[31];
    end
  end
endmodule
`default_nettype wire

// [host_window.sv]
// Behaviour
// - 16KB window at one of 32 switch bases
// - 0000h-1CFFh always hits first RAM page
// - 2000h-3FFFh hits currently selected page
// - Writes anywhere in 1D00h-1DFFh load page
// - Page numbers 00h-1Fh, 32 pages
// - Page N maps to N times 8K
// - Shared RAM spans 0 to 3FFFFh
// - Host path is one byte wide
// - Reads 1E00h-1EFFh fetch controller interrupt vector
// - Writes 1E00h-1EFFh set DTR from bit 0
// - 1F00h-1FFFh pass to controller registers
// - Page read resets controller until page write
// - RAM disabled until first DTR write
// - Channel 0 traffic; RTS from channel 1
// - One acknowledge strobe per vector fetch, held until controller ready
// - Controller strapped bus mode 0, 9.8304 MHz
`timescale 1ns/1ps
`default_nettype none
module host_window
  import window_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  // Host memory bus
  input  wire logic [HOST_ADDR_W-1:0] host_addr,
  input  wire logic                   host_rd,
  input  wire logic                   host_wr,
  input  wire logic [7:0]             host_wdata,
  output logic      [7:0]             host_rdata,
  output logic                        host_ack,
  input  wire logic [BASE_SEL_W-1:0]  base_select_switch,
  // Serial controller register and acknowledge port
  output logic      [7:0]             sc_reg_addr,
  output logic      [7:0]             sc_wdata,
  input  wire logic [7:0]             sc_rdata,
  output logic                        sc_reg_rd,
  output logic                        sc_reg_wr,
  output logic                        sc_intack,
  input  wire logic                   sc_ready,
  output logic                        sc_reset_b,
  output logic      [1:0]             sc_bus_mode,
  output logic                        sc_clk,
  // Serial controller side of the shared RAM
  input  wire logic [RAM_ADDR_W-1:0]  sc_mem_addr,
  input  wire logic                   sc_mem_rd,
  input  wire logic                   sc_mem_wr,
  input  wire logic [7:0]             sc_mem_wdata,
  output logic      [7:0]             sc_mem_rdata,
  // Modem lines
  input  wire logic                   sc_ch1_rts,
  output logic                        line_rts,
  output logic                        line_dtr
);

  ////////////////////////////////////////////////////////////////////////////
  // Window decode

  logic                  in_window;
  logic [WIN_OFS_W-1:0]  win_ofs;
  region_t               region;
  logic                  host_req;

  always_comb begin
    in_window = host_addr[HOST_ADDR_W-1:WIN_OFS_W] == {WIN_BASE_TOP, base_select_switch};
    win_ofs   = host_addr[WIN_OFS_W-1:0];
    region    = decode_region(win_ofs);
    host_req  = in_window && (host_rd ^ host_wr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access state

  access_state_t          state;
  access_state_t          next_state;
  logic [PAGE_W-1:0]      ram_page_select;
  logic [PAGE_W-1:0]      next_ram_page_select;
  logic                   reset_hold;
  logic                   next_reset_hold;
  logic                   ram_enabled;
  logic                   next_ram_enabled;
  logic                   dtr;
  logic                   next_dtr;
  logic [7:0]             rdata;
  logic [7:0]             next_rdata;
  logic [7:0]             sc_addr_q;
  logic [7:0]             next_sc_addr_q;
  logic [7:0]             sc_wdata_q;
  logic [7:0]             next_sc_wdata_q;
  logic                   op_rd;
  logic                   next_op_rd;
  logic                   op_ack;
  logic                   next_op_ack;

  // Host port of the shared RAM
  logic                   ram_a_en;
  logic                   ram_a_we;
  logic [RAM_ADDR_W-1:0]  ram_a_addr;
  logic [7:0]             ram_a_rdata;
  logic                   ram_b_en;
  logic [7:0]             ram_b_rdata;

  always_comb begin
    if (region == RG_BANK1) begin
      ram_a_addr = {ram_page_select, win_ofs[BANK_OFS_W-1:0]};
    end else begin
      ram_a_addr = {PAGE_RESET, win_ofs[BANK_OFS_W-1:0]};
    end
  end

  always_comb begin
    next_state           = state;
    next_ram_page_select = ram_page_select;
    next_reset_hold      = reset_hold;
    next_ram_enabled     = ram_enabled;
    next_dtr             = dtr;
    next_rdata           = rdata;
    next_sc_addr_q       = sc_addr_q;
    next_sc_wdata_q      = sc_wdata_q;
    next_op_rd           = op_rd;
    next_op_ack          = op_ack;
    ram_a_en             = 1'b0;
    ram_a_we             = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (host_req) begin
          next_op_rd = host_rd;
          unique case (region)
            RG_BANK0, RG_BANK1: begin
              if (ram_enabled) begin
                ram_a_en   = 1'b1;
                ram_a_we   = host_wr;
                next_state = ST_RAM;
              end else begin
                next_rdata = IDLE_READ;
                next_state = ST_DONE;
              end
            end
            RG_PAGE: begin
              if (host_wr) begin
                next_ram_page_select = host_wdata[PAGE_W-1:0];
                next_reset_hold      = 1'b0;
              end else begin
                next_reset_hold      = 1'b1;
                next_rdata           = IDLE_READ;
              end
              next_state = ST_DONE;
            end
            RG_ACK: begin
              if (host_wr) begin
                next_dtr         = host_wdata[0];
                next_ram_enabled = 1'b1;
                next_state       = ST_DONE;
              end else if (reset_hold) begin
                next_rdata = IDLE_READ;
                next_state = ST_DONE;
              end else begin
                next_op_ack = 1'b1;
                next_state  = ST_SC;
              end
            end
            default: begin
              if (reset_hold) begin
                next_rdata = IDLE_READ;
                next_state = ST_DONE;
              end else begin
                next_sc_addr_q  = win_ofs[7:0];
                next_sc_wdata_q = host_wdata;
                next_op_ack     = 1'b0;
                next_state      = ST_SC;
              end
            end
          endcase
        end
      end
      ST_RAM: begin
        if (op_rd) next_rdata = ram_a_rdata;
        next_state = ST_DONE;
      end
      ST_SC: begin
        // One acknowledge strobe per fetch, held until the controller answers
        if (sc_ready) begin
          if (op_rd) next_rdata = sc_rdata;
          next_op_ack = 1'b0;
          next_state  = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state           <= ST_IDLE;
      ram_page_select <= PAGE_RESET;
      reset_hold      <= 1'b0;
      ram_enabled     <= 1'b0;
      dtr             <= DTR_RESET;
      rdata           <= IDLE_READ;
      sc_addr_q       <= 8'h00;
      sc_wdata_q      <= 8'h00;
      op_rd           <= 1'b0;
      op_ack          <= 1'b0;
    end else begin
      state           <= next_state;
      ram_page_select <= next_ram_page_select;
      reset_hold      <= next_reset_hold;
      ram_enabled     <= next_ram_enabled;
      dtr             <= next_dtr;
      rdata           <= next_rdata;
      sc_addr_q       <= next_sc_addr_q;
      sc_wdata_q      <= next_sc_wdata_q;
      op_rd           <= next_op_rd;
      op_ack          <= next_op_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    host_rdata  = rdata;
    host_ack    = state == ST_DONE;
    sc_reg_addr = sc_addr_q;
    sc_wdata    = sc_wdata_q;
    sc_intack   = state == ST_SC && op_ack;
    sc_reg_rd   = state == ST_SC && !op_ack && op_rd;
    sc_reg_wr   = state == ST_SC && !op_ack && !op_rd;
    sc_reset_b  = !reset_hold;
    sc_bus_mode = SC_BUS_MODE;
    line_dtr    = dtr;
    line_rts    = sc_ch1_rts;
    // Controller DMA is locked out too until the RAM is enabled
    ram_b_en    = ram_enabled && (sc_mem_rd || sc_mem_wr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared RAM and controller clock

  shared_ram #(
    .ADDR_W (RAM_ADDR_W)
  ) u_ram (
    .mclk    (mclk),
    .a_en    (ram_a_en),
    .a_we    (ram_a_we),
    .a_addr  (ram_a_addr),
    .a_wdata (host_wdata),
    .a_rdata (ram_a_rdata),
    .b_en    (ram_b_en),
    .b_we    (sc_mem_wr),
    .b_addr  (sc_mem_addr),
    .b_wdata (sc_mem_wdata),
    .b_rdata (ram_b_rdata)
  );

  always_comb begin
    sc_mem_rdata = ram_b_rdata;
  end

  sc_clock_gen u_clk (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .sc_clk (sc_clk)
  );

endmodule
`default_nettype wire

// [host_window_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module host_window_sva
  import window_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   rst_b,
  input wire logic [HOST_ADDR_W-1:0] host_addr,
  input wire logic                   host_rd,
  input wire logic                   host_wr,
  input wire logic [7:0]             host_wdata,
  input wire logic [7:0]             host_rdata,
  input wire logic                   host_ack,
  input wire logic [BASE_SEL_W-1:0]  base_select_switch,
  input wire logic [7:0]             sc_reg_addr,
  input wire logic [7:0]             sc_rdata,
  input wire logic                   sc_reg_rd,
  input wire logic                   sc_reg_wr,
  input wire logic                   sc_intack,
  input wire logic                   sc_ready,
  input wire logic                   sc_reset_b,
  input wire logic [1:0]             sc_bus_mode,
  input wire logic                   sc_ch1_rts,
  input wire logic                   line_rts,
  input wire logic                   line_dtr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic       hit;
  logic [5:0] pg;
  assign hit = host_addr[19:14] == {WIN_BASE_TOP, base_select_switch};
  assign pg = host_addr[13:8];
  ////////////////////////////////////////////////////////////////////////
  rts_copy_a: assert property (line_rts == sc_ch1_rts)
    else $error("rts line differs");
  bus_mode_a: assert property (sc_bus_mode == 2'h0)
    else $error("bus mode strap wrong");
  intack_cause_a: assert property ($rose(sc_intack) |-> hit && host_rd && pg == 6'h1E)
    else $error("intack without vector read");
  single_ack_a: assert property (sc_intack && sc_ready |=> !sc_intack && host_ack)
    else $error("intack not ended");
  vector_pass_a: assert property (sc_intack && sc_ready |=> host_rdata == $past(sc_rdata))
    else $error("vector not returned");
  dtr_load_a: assert property (host_ack && host_wr && hit && pg == 6'h1E
    |=> line_dtr == $past(host_wdata[0]))
    else $error("dtr not loaded");
  reset_set_a: assert property (host_ack && host_rd && hit && pg == 6'h1D |=> !sc_reset_b)
    else $error("reset not latched");
  reset_hold_a: assert property (!sc_reset_b && !(host_wr && hit && pg == 6'h1D)
    |=> !sc_reset_b)
    else $error("reset dropped early");
  reg_sel_a: assert property ((sc_reg_rd || sc_reg_wr) |-> sc_reg_addr == host_addr[7:0])
    else $error("register select wrong");
  reg_done_a: assert property ((sc_reg_rd || sc_reg_wr) && sc_ready
    |=> host_ack && !sc_reg_rd && !sc_reg_wr)
    else $error("register access not closed");
  cover property (sc_intack && sc_ready);
  cover property (!sc_reset_b);
  cover property (sc_reg_wr && sc_ready);
endmodule
bind host_window host_window_sva i_sva (.mclk, .rst_b, .host_addr, .host_rd, .host_wr,
  .host_wdata, .host_rdata, .host_ack, .base_select_switch, .sc_reg_addr, .sc_rdata,
  .sc_reg_rd, .sc_reg_wr, .sc_intack, .sc_ready, .sc_reset_b, .sc_bus_mode, .sc_ch1_rts,
  .line_rts, .line_dtr);
`default_nettype wire

// [sc_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module sc_partner (
  input  wire logic       mclk,
  input  wire logic [7:0] sc_reg_addr,
  input  wire logic [7:0] sc_wdata,
  input  wire logic       sc_reg_rd,
  input  wire logic       sc_reg_wr,
  input  wire logic       sc_intack,
  input  wire logic [7:0] vec,
  input  wire logic [7:0] dly,
  output logic      [7:0] sc_rdata,
  output logic            sc_ready
);
  logic [7:0] regs [256];
  logic [7:0] cnt = 8'h00;
  wire logic  busy = sc_reg_rd || sc_reg_wr || sc_intack;
  initial sc_rdata = 8'h00;
  initial sc_ready = 1'b0;
  always @(posedge mclk) begin
    cnt <= (busy && !sc_ready) ? cnt + 8'h01 : 8'h00;
    if (busy && !sc_ready && cnt >= dly) begin
      sc_ready <= 1'b1;
      sc_rdata <= sc_intack ? vec : regs[sc_reg_addr];
      if (sc_reg_wr) begin
        regs[sc_reg_addr] <= sc_wdata;
      end
    end else begin
      sc_ready <= 1'b0;
      // Data not held after the answer: show its inverse
      sc_rdata <= ~sc_rdata;
    end
  end
endmodule
`default_nettype wire

// [host_window_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module host_window_bench;
  import window_pkg::*;
  logic        mclk = 1'b0, rst_b = 1'b0, host_rd = 1'b0, host_wr = 1'b0, host_ack;
  logic        sc_mem_rd = 1'b0, sc_mem_wr = 1'b0, sc_ch1_rts = 1'b0, sc_reg_rd, sc_reg_wr;
  logic        sc_intack, sc_ready, sc_reset_b, sc_clk, line_rts, line_dtr, q;
  logic [19:0] host_addr = 20'h0;
  logic [17:0] sc_mem_addr = 18'h0;
  logic [12:0] o;
  logic [7:0]  host_wdata = 8'h0, sc_mem_wdata = 8'h0, vec = 8'h0, dly = 8'h0;
  logic [7:0]  host_rdata, sc_reg_addr, sc_wdata, sc_rdata, sc_mem_rdata, d, p, v;
  logic [4:0]  base_select_switch = 5'h0, sw = 5'h0;
  logic [1:0]  sc_bus_mode;
  int          fails = 0, compares = 0, seed = 7710, cyc = 0, k = 0;
  always #5 mclk = ~mclk;
  host_window i_dut (.mclk, .rst_b, .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata,
    .host_ack, .base_select_switch, .sc_reg_addr, .sc_wdata, .sc_rdata, .sc_reg_rd, .sc_reg_wr,
    .sc_intack, .sc_ready, .sc_reset_b, .sc_bus_mode, .sc_clk, .sc_mem_addr, .sc_mem_rd,
    .sc_mem_wr, .sc_mem_wdata, .sc_mem_rdata, .sc_ch1_rts, .line_rts, .line_dtr);
  sc_partner i_sc (.mclk, .sc_reg_addr, .sc_wdata, .sc_reg_rd, .sc_reg_wr, .sc_intack, .vec,
    .dly, .sc_rdata, .sc_ready);
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [19:0] w(input logic [13:0] ofs);
    return {WIN_BASE_TOP, sw, ofs};
  endfunction
  // Whole controller clock periods in n mclk cycles
  function automatic int rises(input int n);
    return int'(SC_CLK_HZ * n / MCLK_HZ);
  endfunction
  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic acc(input logic [19:0] a, input logic rd, input logic [7:0] wd,
                     input logic ex, output logic [7:0] rv);
    int n;
    n = 0;
    host_addr <= a;
    host_rd <= rd;
    host_wr <= !rd;
    host_wdata <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (host_ack !== 1'b1 && n < 40);
    chk({7'h0, host_ack}, {7'h0, ex});
    rv = host_rdata;
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic mem(input logic [17:0] a, input logic wr, input logic [7:0] wd,
                     output logic [7:0] rv);
    sc_mem_addr <= a;
    sc_mem_rd <= !wr;
    sc_mem_wr <= wr;
    sc_mem_wdata <= wd;
    @(posedge mclk);
    sc_mem_rd <= 1'b0;
    sc_mem_wr <= 1'b0;
    @(posedge mclk);
    rv = sc_mem_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    mem(18'h00010, 1'b1, 8'h5A, d);
    acc(w(14'h0010), 1'b1, 8'h00, 1'b1, d);
    chk(d, 8'hFF);
    acc(w(14'h1EC3), 1'b0, 8'hFE, 1'b1, d);
    chk({7'h0, line_dtr}, 8'h00);
    acc(w(14'h1E00), 1'b0, 8'h01, 1'b1, d);
    chk({7'h0, line_dtr}, 8'h01);
    acc(w(14'h2ABC), 1'b0, 8'h3C, 1'b1, d);
    mem(18'h00ABC, 1'b0, 8'h00, d);
    chk(d, 8'h3C);
    $display("test power-on done");
    for (int i = 0; i < 8; i++) begin
      sw = 5'($random(seed));
      base_select_switch <= sw;
      sc_ch1_rts <= 1'($random(seed));
      p = (i == 0) ? 8'hFF : (i == 1) ? 8'h20 : 8'($random(seed));
      o = (i == 0) ? 13'h1FFF : 13'($random(seed));
      v = 8'($random(seed));
      acc(w({6'h1D, 8'($random(seed))}), 1'b0, p, 1'b1, d);
      chk({7'h0, line_rts}, {7'h0, sc_ch1_rts});
      acc(w({1'b1, o}), 1'b0, v, 1'b1, d);
      mem({p[4:0], o}, 1'b0, 8'h00, d);
      chk(d, v);
      mem({p[4:0], o}, 1'b1, ~v, d);
      acc(w({1'b1, o}), 1'b1, 8'h00, 1'b1, d);
      chk(d, ~v);
      acc(w({1'b0, o % 13'h1D00}), 1'b0, v, 1'b1, d);
      mem({5'h0, o % 13'h1D00}, 1'b0, 8'h00, d);
      chk(d, v);
    end
    $display("test paging done");
    for (int i = 0; i < 3; i++) begin
      vec <= 8'($random(seed));
      dly <= 8'(i * 6);
      acc(w({6'h1E, 8'($random(seed))}), 1'b1, 8'h00, 1'b1, d);
      chk(d, vec);
      p = 8'($random(seed));
      v = 8'($random(seed));
      acc(w({6'h1F, p}), 1'b0, v, 1'b1, d);
      acc(w({6'h1F, p}), 1'b1, 8'h00, 1'b1, d);
      chk(d, v);
    end
    $display("test controller access done");
    acc(w(14'h1D44), 1'b1, 8'h00, 1'b1, d);
    chk({7'h0, sc_reset_b}, 8'h00);
    acc(w(14'h1F10), 1'b1, 8'h00, 1'b1, d);
    chk(d, 8'hFF);
    acc(w(14'h1D00), 1'b0, 8'h02, 1'b1, d);
    chk({7'h0, sc_reset_b}, 8'h01);
    acc({1'b1, sw + 5'h1, 14'h0010}, 1'b1, 8'h00, 1'b0, d);
    $display("test reset latch and decode done");
    q = sc_clk;
    repeat (1000) begin
      @(posedge mclk);
      k = k + int'(sc_clk && !q);
      q = sc_clk;
    end
    // Phase steps jitter, so a window holds the whole count or one more
    chk({7'h0, k >= rises(1000) && k <= rises(1000) + 1}, 8'h01);
    $display("test controller clock done");
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    acc(w(14'h0010), 1'b1, 8'h00, 1'b1, d);
    chk(d, 8'hFF);
    chk({7'h0, line_dtr}, 8'h00);
    acc(w(14'h1E00), 1'b0, 8'h00, 1'b1, d);
    acc(w(14'h2123), 1'b0, 8'hA5, 1'b1, d);
    mem(18'h00123, 1'b0, 8'h00, d);
    chk(d, 8'hA5);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
